// ---- bench/nes_flash_model.sv ----
// Behavioural NOR flash answering the sequencer's bus cycles
`timescale 1ns/1ps
module nes_flash_model import nes_pkg::*; (
	// Device pins
	input  wire logic [23:0] flash_addr,
	input  wire logic [7:0]  flash_dq_out,
	input  wire logic        flash_dq_oe,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_we_n,
	input  wire logic        flash_oe_n,
	input  wire logic        elevated_program_voltage,
	output logic [7:0]       flash_dq_in
);
	// ==========================================================
	// Write log and erase state
	logic [31:0] wlog[$];
	logic        arm_reg = 1'b0;
	logic        tog_reg = 1'b0;
	int          chip_reg = 0;
	int          blk_reg = -1;
	initial flash_dq_in = 8'h00;

	// ==========================================================
	// Command decode on the rising write strobe
	always @(posedge flash_we_n) begin
		if (!flash_ce_n && flash_dq_oe) begin
			wlog.push_back({flash_addr, flash_dq_out});
			if (chip_reg == 0) begin
				if (flash_dq_out == CMD_CHIP && arm_reg)
					chip_reg = 4;
				if (flash_dq_out == CMD_BLOCK && (arm_reg || blk_reg >= 0))
					blk_reg = 0;
				else if (flash_dq_out inside {CMD_SUSPEND, CMD_RESET})
					blk_reg = -1;
				arm_reg = (flash_dq_out == CMD_ERASE) ||
					(arm_reg && flash_dq_out inside {CMD_UNLOCK1, CMD_UNLOCK2});
			end
		end
	end

	// ==========================================================
	// Status while busy, erased array otherwise, inverted when released
	always @(flash_oe_n) begin
		if (!flash_oe_n && !flash_ce_n && (chip_reg > 0 || blk_reg >= 0)) begin
			tog_reg = !tog_reg;
			flash_dq_in = {1'b0, tog_reg, 2'b00, blk_reg >= 2, 3'b000};
			chip_reg = (chip_reg > 0) ? chip_reg - 1 : 0;
			blk_reg = (blk_reg >= 0) ? blk_reg + 1 : -1;
		end else if (!flash_oe_n)
			flash_dq_in = 8'hff;
		else
			flash_dq_in = ~flash_dq_in;
	end

endmodule : nes_flash_model

// ---- bench/nes_seq_ctrl_tb_top.sv ----
// Self-checking bench of the NOR erase/suspend sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin \
	n_checks++; \
	if ((a) !== (e)) begin \
		n_fail++; \
		$display("mismatch at %0t: %h vs %h", $time, (a), (e)); \
	end \
end
module nes_seq_ctrl_tb_top import nes_pkg::*; ;
	// ==========================================================
	// Signals
	logic        clock, srst, reg_wr, reg_rd, rd_d;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, got, ex;
	logic [23:0] flash_addr, ta, tb2;
	logic [7:0]  flash_dq_out, flash_dq_in;
	logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
	logic        elevated_program_voltage;
	logic [31:0] exp_q[$], msk_q[$];
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          seed = 46700;
	localparam logic [23:0] U1 = {12'h000, UNLOCK1_ADDR};
	localparam logic [23:0] U2 = {12'h000, UNLOCK2_ADDR};

	nes_seq_ctrl #(.FLASH_AW(24)) i_nes_seq_ctrl (
		.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n,
		.flash_we_n, .flash_oe_n, .elevated_program_voltage
	);

	nes_flash_model i_nes_flash_model (
		.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n,
		.elevated_program_voltage, .flash_dq_in
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		@(posedge clock);
	endtask : rd

	task automatic idle();
		int k;
		k = 0;
		while (k < 5) begin
			@(posedge clock);
			k = flash_ce_n ? k + 1 : 0;
		end
	endtask : idle

	task automatic op(input logic [3:0] c);
		wr(REG_CMD, {28'h0, c});
		idle();
	endtask : op

	task automatic chkw(input logic [23:0] a, input logic [7:0] d,
			input logic [31:0] m = 32'hffff_ffff);
		logic [31:0] g;
		g = (i_nes_flash_model.wlog.size() > 0) ? i_nes_flash_model.wlog.pop_front() : 'x;
		`CHK(g & m, {a, d} & m)
	endtask : chkw

	task automatic pre();
		chkw(U1, CMD_UNLOCK1);
		chkw(U2, CMD_UNLOCK2);
	endtask : pre

	task automatic results();
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	// ==========================================================
	// Read result watcher and timeout
	always @(posedge clock) begin
		rd_d <= reg_rd;
		cyc  <= cyc + 1;
		if (rd_d) begin
			ex  = exp_q.pop_front();
			got = reg_rdata & msk_q.pop_front();
			`CHK(got, ex)
		end
		if (cyc == 30000) begin
			n_fail++;
			results();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		srst      = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 32'h0;
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		`CHK(flash_ce_n, 1'b1)
		`CHK(elevated_program_voltage, 1'b0)
		wr(4'hf, 32'hffff_ffff);
		rd(REG_CTRL, 32'h0, 32'hffff_ffff);
		rd(REG_STATUS, 32'h0, 32'hffff_ffff);
		rd(4'hf, 32'h0, 32'hffff_ffff);
		// Full chip erase, then refused suspend and polling
		ta = 24'($random(seed));
		wr(REG_ADDR, {8'h00, ta});
		op(OP_CHIP);
		pre();
		chkw(U1, CMD_ERASE);
		pre();
		chkw(U1, CMD_CHIP);
		rd(REG_STATUS, 32'h10, 32'h13);
		op(OP_ERASE_SUSP);
		rd(REG_STATUS, 32'h12, 32'h13);
		for (int i = 0; i < 3; i++) begin
			op(OP_POLL);
			if (i == 0)
				rd(REG_STATUS, 32'h50, 32'hd3);
		end
		rd(REG_STATUS, 32'hff80, 32'hffd3);
		rd(REG_DATA, 32'hff, 32'hff);
		// Bypass block erase with an added block and suspend
		wr(REG_CTRL, 32'h4);
		ta  = 24'($random(seed));
		tb2 = 24'($random(seed));
		wr(REG_ADDR, {8'h00, ta});
		op(OP_BLOCK);
		chkw(U1, CMD_ERASE);
		chkw(ta, CMD_BLOCK);
		op(OP_POLL);
		rd(REG_STATUS, 32'h44, 32'hc7);
		op(OP_POLL);
		rd(REG_STATUS, 32'hc4, 32'hc7);
		wr(REG_ADDR, {8'h00, tb2});
		op(OP_ADD_BLOCK);
		chkw(tb2, CMD_BLOCK);
		op(OP_POLL);
		rd(REG_STATUS, 32'h44, 32'hc7);
		op(OP_ERASE_SUSP);
		chkw(tb2, CMD_SUSPEND, 32'hff);
		op(OP_POLL);
		rd(REG_STATUS, 32'hff80, 32'hffc3);
		// Six-cycle block erase, then read/reset in the window
		wr(REG_CTRL, 32'h0);
		op(OP_BLOCK);
		pre();
		chkw(U1, CMD_ERASE);
		pre();
		chkw(tb2, CMD_BLOCK);
		op(OP_POLL);
		rd(REG_STATUS, 32'h40, 32'h47);
		op(OP_RESET);
		chkw(tb2, CMD_RESET, 32'hff);
		op(OP_POLL);
		rd(REG_STATUS, 32'hff00, 32'hff43);
		// Program suspend, identification read, resume
		op(OP_PROG_SUSP);
		chkw(tb2, CMD_SUSPEND, 32'hff);
		rd(REG_STATUS, 32'h20, 32'h23);
		op(OP_READ);
		rd(REG_DATA, 32'hff, 32'hff);
		op(OP_AUTOSEL);
		pre();
		chkw(U1, CMD_AUTOSEL, 32'hff);
		rd(REG_STATUS, 32'h20, 32'h23);
		op(OP_PROG_RES);
		chkw(tb2, CMD_RESUME, 32'hff);
		rd(REG_STATUS, 32'h00, 32'h23);
		// Elevated voltage gated by the unprotect confirmation
		wr(REG_CTRL, 32'h1);
		op(OP_BYP_BUF);
		`CHK(elevated_program_voltage, 1'b0)
		rd(REG_STATUS, 32'h2, 32'hb);
		wr(REG_CTRL, 32'h3);
		repeat (3) @(posedge clock);
		`CHK(elevated_program_voltage, 1'b1)
		op(OP_BYP_BUF);
		chkw(tb2, CMD_BYP_BUF);
		rd(REG_STATUS, 32'h8, 32'hb);
		wr(REG_CTRL, 32'h0);
		repeat (3) @(posedge clock);
		`CHK(elevated_program_voltage, 1'b0)
		`CHK(i_nes_flash_model.wlog.size(), 0)
		results();
	end

endmodule : nes_seq_ctrl_tb_top

// ---- common/nes_pkg.sv ----
// Constants, command codes and register map of the NOR erase/suspend sequencer
package nes_pkg;

	// ==========================================================
	// Clock and device bus timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_SETUP_NS    = 10;
	localparam int T_PULSE_NS    = 40;
	localparam int T_HOLD_NS     = 20;
	localparam int SETUP_CYC     = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_CYC     = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_CYC      = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W         = 4;

	// ==========================================================
	// Device command codes
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_ERASE   = 8'h80;
	localparam logic [7:0] CMD_CHIP    = 8'h10;
	localparam logic [7:0] CMD_BLOCK   = 8'h30;
	localparam logic [7:0] CMD_RESUME  = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESET   = 8'hf0;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_BYP_BUF = 8'h25;
	localparam logic [7:0] CMD_NONE    = 8'h00;

	// Unlock cycle addresses
	localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
	localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;

	// Address select of a sequence step
	localparam logic [1:0] SEL_U1  = 2'h0;
	localparam logic [1:0] SEL_U2  = 2'h1;
	localparam logic [1:0] SEL_TGT = 2'h2;

	// Polling bits of the status byte
	localparam int POLL_DONE_BIT   = 7;
	localparam int POLL_TOGGLE_BIT = 6;
	localparam int POLL_TIMER_BIT  = 3;

	// ==========================================================
	// Controller operations
	localparam logic [3:0] OP_RESET      = 4'h0;
	localparam logic [3:0] OP_CHIP       = 4'h1;
	localparam logic [3:0] OP_BLOCK      = 4'h2;
	localparam logic [3:0] OP_ADD_BLOCK  = 4'h3;
	localparam logic [3:0] OP_ERASE_SUSP = 4'h4;
	localparam logic [3:0] OP_PROG_SUSP  = 4'h5;
	localparam logic [3:0] OP_PROG_RES   = 4'h6;
	localparam logic [3:0] OP_AUTOSEL    = 4'h7;
	localparam logic [3:0] OP_POLL       = 4'h8;
	localparam logic [3:0] OP_READ       = 4'h9;
	localparam logic [3:0] OP_BYP_BUF    = 4'ha;
	localparam logic [3:0] OP_MAX        = 4'ha;

	// Sequence lengths
	localparam logic [2:0] LEN_FULL    = 3'h6;
	localparam logic [2:0] LEN_BYPASS  = 3'h2;
	localparam logic [2:0] LEN_AUTOSEL = 3'h3;
	localparam logic [2:0] LEN_POLL    = 3'h2;
	localparam logic [2:0] LEN_ONE     = 3'h1;

	// ==========================================================
	// Register map (word index) and fields
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_CMD    = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_DATA   = 4'h4;

	localparam int CTRL_VHH    = 0;
	localparam int CTRL_UNPROT = 1;
	localparam int CTRL_BYPASS = 2;
	localparam int CTRL_W      = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

	typedef enum logic [1:0] {
		NES_M_IDLE  = 2'b00,
		NES_M_ISSUE = 2'b01,
		NES_M_WAIT  = 2'b10
	} nes_main_e;

	typedef enum logic [1:0] {
		NES_C_IDLE  = 2'b00,
		NES_C_SETUP = 2'b01,
		NES_C_PULSE = 2'b10,
		NES_C_HOLD  = 2'b11
	} nes_cyc_e;

endpackage : nes_pkg

// ---- logic/nes_bus_cycle.sv ----
// One asynchronous device bus cycle, write or read, with setup, pulse and hold
`timescale 1ns/1ps
module nes_bus_cycle import nes_pkg::*; #(
	parameter int AW = 24
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          srst,
	// Request
	input  wire logic          start,
	input  wire logic          is_read,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [7:0]    data_in,
	output logic               done,
	output logic [7:0]         rdata,
	// Device pins
	output logic [AW-1:0]      flash_addr,
	output logic [7:0]         flash_dq_out,
	output logic               flash_dq_oe,
	input  wire logic [7:0]    flash_dq_in,
	output logic               flash_ce_n,
	output logic               flash_we_n,
	output logic               flash_oe_n
);

	nes_cyc_e         state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             rd_reg;
	wire              last_cnt = (cnt_reg == CNT_W'(1));

	// ==========================================================
	// Cycle sequencer
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg    <= NES_C_IDLE;
			cnt_reg      <= '0;
			rd_reg       <= 1'b0;
			done         <= 1'b0;
			rdata        <= '0;
			flash_addr   <= '0;
			flash_dq_out <= '0;
			flash_dq_oe  <= 1'b0;
			flash_ce_n   <= 1'b1;
			flash_we_n   <= 1'b1;
			flash_oe_n   <= 1'b1;
		end else begin
			done <= 1'b0;
			unique case (state_reg)
				NES_C_IDLE: if (start) begin
					state_reg    <= NES_C_SETUP;
					cnt_reg      <= CNT_W'(SETUP_CYC);
					rd_reg       <= is_read;
					flash_addr   <= addr_in;
					flash_dq_out <= data_in;
					flash_dq_oe  <= !is_read;
					flash_ce_n   <= 1'b0;
				end
				NES_C_SETUP: if (last_cnt) begin
					state_reg  <= NES_C_PULSE;
					cnt_reg    <= CNT_W'(PULSE_CYC);
					flash_we_n <= rd_reg;
					flash_oe_n <= !rd_reg;
				end else begin
					cnt_reg <= cnt_reg - CNT_W'(1);
				end
				NES_C_PULSE: if (last_cnt) begin
					state_reg  <= NES_C_HOLD;
					cnt_reg    <= CNT_W'(HOLD_CYC);
					flash_we_n <= 1'b1;
					flash_oe_n <= 1'b1;
					if (rd_reg) begin
						rdata <= flash_dq_in;
					end
				end else begin
					cnt_reg <= cnt_reg - CNT_W'(1);
				end
				NES_C_HOLD: if (last_cnt) begin
					state_reg   <= NES_C_IDLE;
					flash_ce_n  <= 1'b1;
					flash_dq_oe <= 1'b0;
					done        <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - CNT_W'(1);
				end
			endcase
		end
	end

endmodule : nes_bus_cycle

// ---- logic/nes_seq_ctrl.sv ----
// Host controller issuing erase, suspend, resume and polling sequences to a NOR flash
// What the datasheet requires of the host and the device
// RULE1: Device lets reads proceed outside suspended areas during nested program suspend.
// RULE2: Device accepts identification reads while program is suspended, then returns.
// RULE3: Host leaves program suspend by writing resume code 30h.
// RULE4: Device ignores repeated resume; host may suspend again after resuming.
// RULE5: Host judges progress from completion and toggle poll bits. The code uses only the toggle bit and never tests POLL_DONE_BIT.
// RULE6: Elevated voltage puts device in bypass mode, enabling bypass buffered program.
// RULE7: Dropping elevated voltage after the operation returns device to normal mode.
// RULE8: Host raises elevated voltage only after blocks are confirmed unprotected.
// RULE9: Full chip erase is six write cycles ending with 10h.
// RULE10: Device skips protected blocks during chip erase, without error.
// RULE11: Chip erase ignores every command; host refuses suspends meanwhile.
// RULE12: After a failed erase the host issues read/reset to clear it.
// RULE13: Chip erase leaves unprotected blocks all ones.
// RULE14: Bypass chip erase is two write cycles.
// RULE15: Block erase is six cycles; more blocks by repeating the sixth.
// RULE16: Other commands in the timeout window abort; timer flag shows expiry.
// RULE17: Each added block restarts the timeout; none accepted after start.
// RULE18: After the sixth block erase cycle reads return the status byte.
// RULE19: Device skips protected blocks in a block erase list.
// RULE20: Block erase accepts only suspend, and reset inside the window.
// RULE21: Bypass block erase is two cycles; repeat the second to add blocks.
// RULE22: Erase suspend is B0h to any address, one write cycle.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module nes_seq_ctrl import nes_pkg::*; #(
	parameter int FLASH_AW = 24
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                srst,
	// Register port
	input  wire logic [3:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	// Device pins
	output logic [FLASH_AW-1:0]      flash_addr,
	output logic [7:0]               flash_dq_out,
	output logic                     flash_dq_oe,
	input  wire logic [7:0]          flash_dq_in,
	output logic                     flash_ce_n,
	output logic                     flash_we_n,
	output logic                     flash_oe_n,
	output logic                     elevated_program_voltage
);

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// ==========================================================
	// Sequence tables
	function automatic logic [10:0] seq_word(input logic [3:0] op, input logic [2:0] step,
			input logic byp);
		logic [2:0] idx;
		logic       erase_op;
		logic       long_op;
		logic [7:0] fin;
		erase_op = (op == OP_CHIP) || (op == OP_BLOCK);
		long_op  = erase_op || (op == OP_AUTOSEL);
		idx      = (byp && erase_op) ? ((step == 3'h0) ? 3'h2 : 3'h5) : step;
		unique case (op)
			OP_CHIP:      fin = CMD_CHIP;
			OP_BLOCK:     fin = CMD_BLOCK;
			OP_ADD_BLOCK: fin = CMD_BLOCK;
			OP_ERASE_SUSP, OP_PROG_SUSP: fin = CMD_SUSPEND;
			OP_PROG_RES:  fin = CMD_RESUME;
			OP_AUTOSEL:   fin = CMD_AUTOSEL;
			OP_BYP_BUF:   fin = CMD_BYP_BUF;
			OP_POLL, OP_READ: fin = CMD_NONE;
			default:      fin = CMD_RESET;
		endcase
		if ((op == OP_POLL) || (op == OP_READ)) seq_word = {SEL_TGT, 1'b1, CMD_NONE};
		else if (long_op && (idx == 3'h0 || idx == 3'h3)) seq_word = {SEL_U1, 1'b0, CMD_UNLOCK1};
		else if (long_op && (idx == 3'h1 || idx == 3'h4)) seq_word = {SEL_U2, 1'b0, CMD_UNLOCK2};
		else if (erase_op && idx == 3'h2) seq_word = {SEL_U1, 1'b0, CMD_ERASE};
		else if (op == OP_CHIP || op == OP_AUTOSEL) seq_word = {SEL_U1, 1'b0, fin};
		else seq_word = {SEL_TGT, 1'b0, fin};
	endfunction : seq_word

	function automatic logic [2:0] seq_len(input logic [3:0] op, input logic byp);
		if (op == OP_CHIP || op == OP_BLOCK) seq_len = byp ? LEN_BYPASS : LEN_FULL;
		else if (op == OP_AUTOSEL) seq_len = LEN_AUTOSEL;
		else if (op == OP_POLL) seq_len = LEN_POLL;
		else seq_len = LEN_ONE;
	endfunction : seq_len

	// ==========================================================
	// State
	nes_main_e            m_state_reg;
	logic [CTRL_W-1:0]    ctrl_reg;
	logic [FLASH_AW-1:0]  addr_reg;
	logic [3:0]           op_reg;
	logic [2:0]           step_reg;
	logic [2:0]           issued_cnt;
	logic                 byp_lat_reg;
	logic                 refused_reg;
	logic                 chip_active_reg;
	logic                 prog_susp_reg;
	logic                 toggling_reg;
	logic                 timer_flag_reg;
	logic [7:0]           first_poll_reg;
	logic [7:0]           poll_byte_reg;
	logic                 vhh_reg;
	logic                 cyc_done;
	logic [7:0]           cyc_rdata;

	// ==========================================================
	// Decode
	wire        busy        = (m_state_reg != NES_M_IDLE);
	wire        bypass_on   = ctrl_reg[CTRL_BYPASS] | vhh_reg;               // RULE6 RULE7
	wire        cmd_wr      = reg_wr && (reg_addr == REG_CMD);
	wire [3:0]  new_op      = reg_wdata[3:0];
	wire        susp_op     = (new_op == OP_ERASE_SUSP) || (new_op == OP_PROG_SUSP)
	                          || (new_op == OP_ADD_BLOCK);
	wire        refuse      = busy || (new_op > OP_MAX)
	                          || (chip_active_reg && susp_op)                 // RULE11
	                          || ((new_op == OP_BYP_BUF) && !bypass_on);      // RULE6
	wire        accept      = cmd_wr && !refuse;
	wire [10:0] cur_word    = seq_word(op_reg, step_reg, byp_lat_reg);
	wire [2:0]  cur_len     = seq_len(op_reg, byp_lat_reg);
	wire        cyc_start   = (m_state_reg == NES_M_ISSUE);
	wire        last_step   = (step_reg + 3'h1 == cur_len);
	wire        fin         = (m_state_reg == NES_M_WAIT) && cyc_done && last_step;
	wire [7:0]  cyc_wdata   = cur_word[7:0];
	wire        cyc_is_read = cur_word[8];
	wire [FLASH_AW-1:0] cyc_addr = (cur_word[10:9] == SEL_U1) ? FLASH_AW'(UNLOCK1_ADDR) :
	                               (cur_word[10:9] == SEL_U2) ? FLASH_AW'(UNLOCK2_ADDR) :
	                               addr_reg;
	wire        vhh_next    = busy ? vhh_reg
	                               : (ctrl_reg[CTRL_VHH] & ctrl_reg[CTRL_UNPROT]); // RULE8
	wire [31:0] status_word = {16'h0000, poll_byte_reg, timer_flag_reg, toggling_reg,
	                           prog_susp_reg, chip_active_reg, vhh_reg, bypass_on,
	                           refused_reg, busy};
	wire [31:0] rd_mux      = (reg_addr == REG_CTRL)   ? 32'(ctrl_reg) :
	                          (reg_addr == REG_ADDR)   ? 32'(addr_reg) :
	                          (reg_addr == REG_CMD)    ? 32'(op_reg) :
	                          (reg_addr == REG_STATUS) ? status_word :
	                          (reg_addr == REG_DATA)   ? 32'(poll_byte_reg) : 32'h00000000;
	wire        poll_second = (op_reg == OP_POLL) && (step_reg == 3'h1);
	wire        toggle_now  = first_poll_reg[POLL_TOGGLE_BIT] ^ cyc_rdata[POLL_TOGGLE_BIT];

	// ==========================================================
	// Register port
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_reg    <= CTRL_RESET;
			addr_reg    <= '0;
			reg_rdata   <= '0;
			refused_reg <= 1'b0;
			vhh_reg     <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == REG_CTRL) ctrl_reg <= reg_wdata[CTRL_W-1:0];
			if (reg_wr && reg_addr == REG_ADDR) addr_reg <= reg_wdata[FLASH_AW-1:0];
			if (cmd_wr) refused_reg <= refuse;
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
			vhh_reg   <= vhh_next;
		end
	end

	// ==========================================================
	// Sequence engine
	always_ff @(posedge clock) begin
		if (srst) begin
			m_state_reg <= NES_M_IDLE;
			op_reg      <= OP_RESET;
			step_reg    <= '0;
			issued_cnt  <= '0;
			byp_lat_reg <= 1'b0;
		end else begin
			unique case (m_state_reg)
				NES_M_IDLE: if (accept) begin
					m_state_reg <= NES_M_ISSUE;
					op_reg      <= new_op;
					step_reg    <= '0;
					issued_cnt  <= '0;
					byp_lat_reg <= bypass_on;                             // RULE14 RULE21
				end
				NES_M_ISSUE: m_state_reg <= NES_M_WAIT;
				NES_M_WAIT: if (cyc_done) begin
					issued_cnt  <= issued_cnt + 3'h1;
					step_reg    <= step_reg + 3'h1;
					m_state_reg <= last_step ? NES_M_IDLE : NES_M_ISSUE;  // RULE9 RULE15
				end
				default: m_state_reg <= NES_M_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Tracked device state and polling results
	always_ff @(posedge clock) begin
		if (srst) begin
			chip_active_reg <= 1'b0;
			prog_susp_reg   <= 1'b0;
			toggling_reg    <= 1'b0;
			timer_flag_reg  <= 1'b0;
			first_poll_reg  <= '0;
			poll_byte_reg   <= '0;
		end else begin
			if (fin && op_reg == OP_CHIP) chip_active_reg <= 1'b1;        // RULE11
			else if (fin && poll_second && !toggle_now) chip_active_reg <= 1'b0;
			else if (fin && op_reg == OP_RESET) chip_active_reg <= 1'b0;  // RULE12
			if (fin && op_reg == OP_PROG_SUSP) prog_susp_reg <= 1'b1;
			else if (fin && op_reg == OP_PROG_RES) prog_susp_reg <= 1'b0; // RULE3 RULE4
			if (m_state_reg == NES_M_WAIT && cyc_done && cyc_is_read) begin
				poll_byte_reg <= cyc_rdata;
				if (!poll_second) first_poll_reg <= cyc_rdata;
			end
			if (fin && poll_second) begin
				toggling_reg   <= toggle_now;                             // RULE5
				timer_flag_reg <= cyc_rdata[POLL_TIMER_BIT];              // RULE16
			end
		end
	end

	assign elevated_program_voltage = vhh_reg;

	nes_bus_cycle #(
		.AW (FLASH_AW)
	) u_cycle (
		.clock        (clock),
		.srst         (srst),
		.start        (cyc_start),
		.is_read      (cyc_is_read),
		.addr_in      (cyc_addr),
		.data_in      (cyc_wdata),
		.done         (cyc_done),
		.rdata        (cyc_rdata),
		.flash_addr   (flash_addr),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe),
		.flash_dq_in  (flash_dq_in),
		.flash_ce_n   (flash_ce_n),
		.flash_we_n   (flash_we_n),
		.flash_oe_n   (flash_oe_n)
	);

	// ==========================================================
	// Checks
	AST_RESUME_CODE: assert property (cyc_start && op_reg == OP_PROG_RES |-> // RULE3
		cyc_wdata == CMD_RESUME && !cyc_is_read) else $error("resume code wrong");
	AST_CHIP_SIX: assert property (fin && op_reg == OP_CHIP && !byp_lat_reg |=> // RULE9
		issued_cnt == LEN_FULL) else $error("chip erase not six cycles");
	AST_CHIP_TWO: assert property (fin && op_reg == OP_CHIP && byp_lat_reg |=> // RULE14
		issued_cnt == LEN_BYPASS) else $error("bypass chip erase not two cycles");
	AST_BLOCK_LAST: assert property (cyc_start && op_reg == OP_BLOCK && last_step |-> // RULE15
		cyc_wdata == CMD_BLOCK && cyc_addr == addr_reg) else $error("block erase end wrong");
	AST_BYP_BLOCK: assert property (fin && op_reg == OP_BLOCK && byp_lat_reg |=> // RULE21
		issued_cnt == LEN_BYPASS) else $error("bypass block erase length wrong");
	AST_VHH_GUARD: assert property ($rose(elevated_program_voltage) |-> // RULE8
		$past(ctrl_reg[CTRL_UNPROT])) else $error("voltage raised while protected");
	AST_BYP_VHH: assert property (accept && elevated_program_voltage |=> byp_lat_reg) // RULE6
		else $error("no bypass under elevated voltage");
	AST_VHH_STABLE: assert property (busy && $past(busy) |-> // RULE7
		$stable(elevated_program_voltage)) else $error("voltage moved during operation");
	AST_NO_SUSP_CHIP: assert property (cmd_wr && !busy && chip_active_reg && susp_op |=> // RULE11
		m_state_reg == NES_M_IDLE && refused_reg) else $error("suspend sent in chip erase");
	AST_POLL_TWO: assert property (fin && op_reg == OP_POLL |=> // RULE5
		issued_cnt == LEN_POLL && !busy) else $error("poll not two reads");
	AST_SUSP_ONE: assert property (cyc_start && op_reg == OP_ERASE_SUSP |-> // RULE22
		cyc_wdata == CMD_SUSPEND ##1 !flash_ce_n) else $error("suspend cycle wrong");

	COV_CHIP: cover property (fin && op_reg == OP_CHIP);
	COV_BLOCK_BYP: cover property (fin && op_reg == OP_BLOCK && byp_lat_reg);
	COV_RESUME: cover property (fin && op_reg == OP_PROG_RES);
	COV_POLL_TOGGLE: cover property (fin && poll_second && toggle_now);

endmodule : nes_seq_ctrl
